// file: logic/rxu_pkg.sv
// Shared constants for the buffered serial receiver: register map, field positions,
// reset values, receiver states.
// Assumes a 32-bit APB register bus with byte addresses.
package rxu_pkg;

    localparam int RXU_APB_AW = 4;

    // Register byte offsets
    localparam logic [RXU_APB_AW-1:0] RXU_OFS_STATUS_A = 4'h0;
    localparam logic [RXU_APB_AW-1:0] RXU_OFS_CONTROL_B = 4'h4;
    localparam logic [RXU_APB_AW-1:0] RXU_OFS_FRAME_CONTROL = 4'h8;
    localparam logic [RXU_APB_AW-1:0] RXU_OFS_DATA = 4'hC;

    // serial_status_a bit positions
    localparam int RXU_STA_RXC_BIT = 7;
    localparam int RXU_STA_FE_BIT = 4;
    localparam int RXU_STA_DOR_BIT = 3;
    localparam int RXU_STA_PE_BIT = 2;

    // serial_control_b bit positions
    localparam int RXU_CTB_RECEIVE_COMPLETE_IRQ_ENABLE_BIT = 7;
    localparam int RXU_CTB_RECEIVER_ENABLE_BIT = 4;
    localparam int RXU_CTB_SIZE2_BIT = 2;
    localparam int RXU_CTB_RX9_BIT = 1;
    localparam int RXU_CTB_TX9_BIT = 0;

    // serial_frame_control bit positions
    localparam int RXU_FRC_SYNC_BIT = 6;
    localparam int RXU_FRC_PAR_EN_BIT = 5;
    localparam int RXU_FRC_PAR_ODD_BIT = 4;
    localparam int RXU_FRC_STOP2_BIT = 3;
    localparam int RXU_FRC_SIZE_HI_BIT = 2;
    localparam int RXU_FRC_SIZE_LO_BIT = 1;

    // Reset values
    localparam logic [7:0] RXU_CONTROL_B_RESET = 8'h00;
    localparam logic [7:0] RXU_FRAME_CONTROL_RESET = 8'h06;

    // Character size codes and lengths
    localparam logic [2:0] RXU_SIZE_CODE_NINE = 3'h7;
    localparam logic [3:0] RXU_NINE_BITS = 4'h9;
    localparam logic [3:0] RXU_MIN_BITS = 4'h5;

    // Buffer entry layout: {overrun, frame error, parity error, data[8:0]}
    localparam int RXU_ENTRY_W = 12;
    localparam int RXU_ENT_DOR_BIT = 11;
    localparam int RXU_ENT_FE_BIT = 10;
    localparam int RXU_ENT_PE_BIT = 9;

    typedef enum logic [4:0] {
        RXU_IDLE = 5'b00001,
        RXU_DATA = 5'b00010,
        RXU_PARITY = 5'b00100,
        RXU_STOP = 5'b01000,
        RXU_WAIT = 5'b10000
    } rxu_state_t;

endpackage

// file: logic/rxu_buf.sv
// Two-entry receive buffer holding one frame and its status per entry.
// Assumes push only when not full; pop is ignored while empty; flush wins over both.
`timescale 1ns/10ps
`default_nettype none
module rxu_buf #(
    parameter int WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic full
);

    logic [WIDTH-1:0] mem [0:1];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    wire do_push = push && !full && !flush;
    wire do_pop = pop && !empty && !flush;

    assign empty = (count_reg == 2'h0);
    assign full = (count_reg == 2'h2);
    assign head = mem[rd_ptr_reg];

    always_comb begin
        count_next = count_reg;
        if (flush) begin
            count_next = 2'h0;
        end else if (do_push && !do_pop) begin
            count_next = count_reg + 2'h1;
        end else if (do_pop && !do_push) begin
            count_next = count_reg - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            count_reg <= count_next;
            if (flush) begin
                wr_ptr_reg <= 1'b0;
                rd_ptr_reg <= 1'b0;
            end else begin
                if (do_push) begin
                    wr_ptr_reg <= !wr_ptr_reg;
                end
                if (do_pop) begin
                    rd_ptr_reg <= !rd_ptr_reg;
                end
            end
        end
    end

    // Storage needs no reset; reads of an empty buffer are gated by the owner
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

endmodule
`default_nettype wire

// file: logic/rxu_receiver.sv
// Buffered serial receiver with APB register access.
// Assumes clock recovery elsewhere gives one baud_sample_tick per bit centre in
// asynchronous mode; in synchronous mode bits are taken on rising edges of the
// transfer clock pin. All pin inputs are synchronous to pclk.
//
// Contract
// - Receiver enable hands the receive pin over from port use to serial input.
// - Synchronous mode samples bits on the external transfer clock pin.
// - After a start bit, shift bits up to first stop bit; ignore second.
// - First stop bit moves the frame into the buffer, read via data register.
// - Unused upper bits of short characters read as zero.
// - Ninth bit and status kept per entry; data read advances to next entry.
// - Receive-complete flag is one exactly while the buffer holds unread data.
// - Disabling empties buffer, drops frame, frees pin, clears receive-complete.
// - Interrupt holds while receive-complete, its enable and global enable are set.
// - Error flags readable in status and stored with their frame.
// - Status register writes never alter the error flags.
// - Error flags never raise an interrupt.
// - Frame error shows head frame's first stop bit, whatever the stop count.
// - Overrun when buffer full, a frame waits, and a new start arrives.
// - Overrun indication clears once a frame is moved into the buffer.
// - Parity error set only for failed checks with checking enabled.
// - With parity enabled compute parity, compare, store result with frame.
// - Disable takes effect at once; a reception in progress is lost.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rxu_receiver
    import rxu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_pin_in,
    input wire logic sync_transfer_clock_pin,
    input wire logic baud_sample_tick,
    input wire logic global_irq_enable,
    output logic rx_pin_override,
    output logic rx_irq
);

    // Register state
    logic [7:0] control_b_reg;
    logic [7:0] frame_control_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic pop_ok_reg;
    logic rx_irq_reg;
    logic pin_override_reg;

    // Receiver state
    rxu_state_t state_reg;
    rxu_state_t state_next;
    logic [8:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic parity_bit_reg;
    logic parity_chk_reg;
    logic stop_bit_reg;
    logic lost_reg;
    logic xck_prev_reg;

    // Buffer interface
    logic [RXU_ENTRY_W-1:0] buf_head;
    logic buf_empty;
    logic buf_full;

    // Control fields
    wire rx_enable = control_b_reg[RXU_CTB_RECEIVER_ENABLE_BIT];
    wire rxc_irq_en = control_b_reg[RXU_CTB_RECEIVE_COMPLETE_IRQ_ENABLE_BIT];
    wire sync_mode = frame_control_reg[RXU_FRC_SYNC_BIT];
    wire parity_en = frame_control_reg[RXU_FRC_PAR_EN_BIT];
    wire parity_odd = frame_control_reg[RXU_FRC_PAR_ODD_BIT];
    wire [2:0] size_code = {control_b_reg[RXU_CTB_SIZE2_BIT],
                            frame_control_reg[RXU_FRC_SIZE_HI_BIT:RXU_FRC_SIZE_LO_BIT]};
    wire [3:0] char_bits = (size_code == RXU_SIZE_CODE_NINE) ? RXU_NINE_BITS
                         : (RXU_MIN_BITS + {2'b00, size_code[1:0]});

    // APB decode
    wire [RXU_APB_AW-1:0] reg_ofs = paddr[RXU_APB_AW-1:0];
    wire addr_hit_upper = (paddr[31:RXU_APB_AW] == '0);
    wire sel_status = addr_hit_upper && (reg_ofs == RXU_OFS_STATUS_A);
    wire sel_control = addr_hit_upper && (reg_ofs == RXU_OFS_CONTROL_B);
    wire sel_frame = addr_hit_upper && (reg_ofs == RXU_OFS_FRAME_CONTROL);
    wire sel_data = addr_hit_upper && (reg_ofs == RXU_OFS_DATA);
    wire addr_mapped = sel_status || sel_control || sel_frame || sel_data;
    wire apb_access = psel && penable && !pready_reg;
    wire apb_done = psel && penable && pready_reg;
    wire wr_done = apb_done && pwrite && !pslverr_reg;
    wire wr_control = wr_done && sel_control;
    wire wr_frame = wr_done && sel_frame;

    // Data read advances the buffer only if it returned a real entry
    wire buf_pop = apb_done && !pwrite && sel_data && pop_ok_reg;

    // Pin hand-over: serial input only while the receiver owns the pin
    wire rx_in = rxd_pin_in || !rx_enable;

    // Bit sample moment: pin clock edge in synchronous mode, recovered tick otherwise
    wire xck_rise = sync_transfer_clock_pin && !xck_prev_reg;
    wire sample = sync_mode ? xck_rise : baud_sample_tick;

    // Head entry fields, gated so an empty buffer reads as zero
    wire head_valid = !buf_empty;
    wire head_fe = head_valid && buf_head[RXU_ENT_FE_BIT];
    wire head_dor = head_valid && buf_head[RXU_ENT_DOR_BIT];
    wire head_pe = head_valid && buf_head[RXU_ENT_PE_BIT];
    wire [8:0] head_data = head_valid ? buf_head[8:0] : 9'h000;

    // Status read shows the head frame flags; no write path reaches them
    wire [7:0] status_rd = {head_valid, 2'b00, head_fe, head_dor, head_pe, 2'b00};
    wire [7:0] control_rd = {control_b_reg[7:2], head_data[8],
                             control_b_reg[RXU_CTB_TX9_BIT]};
    wire [31:0] rd_mux = sel_status ? {24'h000000, status_rd}
                       : sel_control ? {24'h000000, control_rd}
                       : sel_frame ? {24'h000000, frame_control_reg}
                       : sel_data ? {23'h000000, head_data}
                       : 32'h00000000;

    // Receiver sequencing
    wire start_seen = sample && !rx_in;
    wire last_data = (bit_cnt_reg == (char_bits - 4'h1));
    wire frame_waiting = (state_reg == RXU_WAIT);
    wire buf_push = frame_waiting && !buf_full && rx_enable;
    wire overrun_hit = frame_waiting && buf_full && start_seen;
    wire data_parity = ^shift_reg;

    // Even: data plus parity bit has even weight; odd: odd weight
    wire parity_fail = data_parity ^ rx_in ^ parity_odd;

    wire [RXU_ENTRY_W-1:0] push_entry = {lost_reg, !stop_bit_reg, parity_chk_reg,
                                         shift_reg};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RXU_IDLE: begin
                // A high sample here is idle or a second stop bit and is ignored
                if (start_seen) begin
                    state_next = RXU_DATA;
                end
            end
            RXU_DATA: begin
                if (sample && last_data) begin
                    state_next = parity_en ? RXU_PARITY : RXU_STOP;
                end
            end
            RXU_PARITY: begin
                if (sample) begin
                    state_next = RXU_STOP;
                end
            end
            RXU_STOP: begin
                if (sample) begin
                    state_next = RXU_WAIT;
                end
            end
            RXU_WAIT: begin
                if (start_seen) begin
                    state_next = RXU_DATA;
                end else if (!buf_full) begin
                    state_next = RXU_IDLE;
                end
            end
            default: begin
                state_next = RXU_IDLE;
            end
        endcase
        if (!rx_enable) begin
            state_next = RXU_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RXU_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 9'h000;
            parity_bit_reg <= 1'b0;
            parity_chk_reg <= 1'b0;
            stop_bit_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (!rx_enable) begin
                bit_cnt_reg <= 4'h0;
            end else if (start_seen && (state_reg == RXU_IDLE || frame_waiting)) begin
                // Clearing the whole register zeroes unused high bits
                bit_cnt_reg <= 4'h0;
                shift_reg <= 9'h000;
                parity_chk_reg <= 1'b0;
            end else if (sample && state_reg == RXU_DATA) begin
                shift_reg[bit_cnt_reg] <= rx_in;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (sample && state_reg == RXU_PARITY) begin
                parity_bit_reg <= rx_in;
                parity_chk_reg <= parity_en && parity_fail;
            end else if (sample && state_reg == RXU_STOP) begin
                stop_bit_reg <= rx_in;
            end
        end
    end

    // Overrun marker: set on a lost frame, cleared once a frame reaches the buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_reg <= 1'b0;
        end else if (!rx_enable) begin
            lost_reg <= 1'b0;
        end else if (overrun_hit) begin
            lost_reg <= 1'b1;
        end else if (buf_push) begin
            lost_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xck_prev_reg <= 1'b0;
        end else begin
            xck_prev_reg <= sync_transfer_clock_pin;
        end
    end

    rxu_buf #(
        .WIDTH(RXU_ENTRY_W)
    ) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .flush(!rx_enable),
        .push(buf_push),
        .push_data(push_entry),
        .pop(buf_pop),
        .head(buf_head),
        .empty(buf_empty),
        .full(buf_full)
    );

    // Software-writable registers; status has no writable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_b_reg <= RXU_CONTROL_B_RESET;
            frame_control_reg <= RXU_FRAME_CONTROL_RESET;
        end else begin
            if (wr_control) begin
                control_b_reg <= pwdata[7:0];
            end
            if (wr_frame) begin
                frame_control_reg <= pwdata[7:0];
            end
        end
    end

    // One wait state: read data is captured when pready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pop_ok_reg <= 1'b0;
        end else begin
            pready_reg <= apb_access;
            if (apb_access) begin
                pslverr_reg <= !addr_mapped;
                prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
                pop_ok_reg <= head_valid;
            end else begin
                pslverr_reg <= 1'b0;
                pop_ok_reg <= 1'b0;
            end
        end
    end

    // Level interrupt from receive-complete only; error flags take no part
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_irq_reg <= 1'b0;
            pin_override_reg <= 1'b0;
        end else begin
            rx_irq_reg <= head_valid && rxc_irq_en && global_irq_enable;
            pin_override_reg <= rx_enable;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rx_irq = rx_irq_reg;
    assign rx_pin_override = pin_override_reg;

endmodule
`default_nettype wire

// file: verification/rxu_receiver_properties.sv
// Port-level checker for the buffered serial receiver.
// Assumes one pclk domain and an APB master holding requests until pready.
`timescale 1ns/10ps
`default_nettype none
module rxu_receiver_chk
    import rxu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic global_irq_enable,
    input wire logic rx_pin_override,
    input wire logic rx_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic done = psel && penable && pready;
    wire logic stat_rd = done && !pwrite && paddr == 32'h0;
    wire logic ctb_wr = done && pwrite && paddr == 32'h4;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_off;
        !rx_pin_override [*4];
    endsequence
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_ready_wait;
        s_setup ##1 s_access |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready late");
    property p_unmapped;
        done && paddr[31:4] != 28'h0 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
    property p_status_clean;
        stat_rd |-> (prdata & 32'hFFFFFF63) == 32'h0;
    endproperty
    a_status_clean: assert property (p_status_clean) else $error("status bits");
    property p_override;
        ctb_wr |-> ##2 rx_pin_override == $past(pwdata[RXU_CTB_RECEIVER_ENABLE_BIT], 2);
    endproperty
    a_override: assert property (p_override) else $error("pin override");
    property p_irq_global;
        rx_irq |-> $past(global_irq_enable);
    endproperty
    a_irq_global: assert property (p_irq_global) else $error("irq unmasked");
    property p_off_quiet;
        s_off |-> !rx_irq;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
    property p_off_empty;
        s_off ##0 stat_rd |-> !prdata[RXU_STA_RXC_BIT];
    endproperty
    a_off_empty: assert property (p_off_empty) else $error("data while off");
endmodule
bind rxu_receiver rxu_receiver_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
    .rx_pin_override(rx_pin_override), .rx_irq(rx_irq));
`default_nettype wire

// file: verification/rxu_tx_model.sv
// Remote serial transmitter: start bit, then len bits LSB first, six pclk per bit.
// Line idles high; tick and transfer clock stand still outside frames.
`timescale 1ns/10ps
`default_nettype none
module rxu_tx_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic sync,
    input wire logic [11:0] bits,
    input wire logic [3:0] len,
    output logic rxd,
    output logic sck,
    output logic tick,
    output logic busy
);
    logic [11:0] sh;
    logic [3:0] left;
    logic [2:0] ph;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rxd, sck, tick, busy, sh, left, ph} <= {1'b1, 22'h0};
        end else if (!busy) begin
            {sck, tick} <= 2'b00;
            if (start) begin
                {busy, rxd, sh, left, ph} <= {2'b10, bits, len, 3'h0};
            end
        end else begin
            ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            // Only one bit clock toggles, so a wrong clock choice loses the frame
            tick <= !sync && ph == 3'h1;
            sck <= sync && (ph == 3'h1 || ph == 3'h2);
            if (ph == 3'h5 && left == 4'h0) begin
                {busy, rxd} <= 2'b01;
            end else if (ph == 3'h5) begin
                {rxd, sh, left} <= {sh[0], sh >> 1, left - 4'h1};
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_rxu_receiver.sv
// Self-checking bench: APB master, frame source and a queue model of the buffer.
// Assumes one wait state per APB access and six pclk per serial bit.
`timescale 1ns/10ps
`default_nettype none
module tb_rxu_receiver
    import rxu_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rdata, cbv = 0, seed = 71;
    logic pready, pslverr, rerr, rxd, sck, tick, gie = 1, ovr, irq, start = 0, sync = 0, busy;
    logic [11:0] fbits = 0;
    logic [3:0] flen = 0;
    logic [2:0] sz;
    logic [11:0] q[$];
    int failures = 0, check_count = 0;
    always #2.5 pclk = ~pclk;
    rxu_receiver u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_pin_in(rxd), .sync_transfer_clock_pin(sck),
        .baud_sample_tick(tick), .global_irq_enable(gie), .rx_pin_override(ovr), .rx_irq(irq));
    rxu_tx_model u_tx (.pclk(pclk), .presetn(presetn), .start(start), .sync(sync),
        .bits(fbits), .len(flen), .rxd(rxd), .sck(sck), .tick(tick), .busy(busy));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        int t;
        t = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) failures++;
        {rdata, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic cfg(input logic [31:0] cb, input logic [31:0] fc);
        cbv = cb;
        acc(1, 8, fc);
        acc(1, 4, cb);
    endtask
    task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic odd,
        input logic badp, input logic stp, input logic wt);
        int t;
        d = d & 9'((1 << nb) - 1);
        fbits <= 12'(d) | (12'((^d ^ odd ^ badp) && pen) << nb) | (12'(stp) << (nb + 32'(pen)));
        flen <= 4'(nb + 32'(pen) + 1);
        q.push_back({1'b0, !stp, pen && badp, d});
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        @(posedge pclk);
        for (t = 0; t < 200 && wt && busy !== 1'b0; t++) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask
    task automatic drain();
        logic [11:0] e;
        while (q.size() > 0) begin
            e = q.pop_front();
            acc(0, 0, 0);
            chk(rdata, 32'({1'b1, 2'b0, e[10], e[11], e[9], 2'b0}));
            acc(0, 4, 0);
            chk(rdata, cbv | (32'(e[8]) << 1));
            acc(0, 32'hC, 0);
            chk(rdata, 32'(e[8:0]));
        end
        acc(0, 0, 0);
        chk(rdata, 0);
        chk(32'(irq), 0);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(0, 4, 0);
        chk(rdata, 32'(RXU_CONTROL_B_RESET));
        acc(0, 8, 0);
        chk(rdata, 32'(RXU_FRAME_CONTROL_RESET));
        acc(0, 32'h10, 0);
        chk(32'(rerr), 1);
        // Stop errors and all four parity cases, even and odd
        for (int k = 0; k < 8; k++) begin
            cfg(32'h90, k < 4 ? 32'h06 : 32'h26 | (32'(k % 2) << 4));
            send(9'(rnd()), 8, k >= 4, k % 2, k / 2 % 2, k % 3 != 2, 1);
            chk(32'(irq), 1);
            drain();
        end
        // Size codes 0 to 3 and 7; one in sync mode with two stop bits; irq masked on three of five
        for (int s = 0; s < 5; s++) begin
            sz = (s == 4) ? 3'h7 : 3'(s);
            gie <= 1'(s % 2);
            sync <= s == 1;
            cfg(32'h90 | (32'(sz[2]) << 2), (32'(sz[1:0]) << 1) | (s == 1 ? 32'h48 : 0));
            send(9'(rnd()), sz == 3'h7 ? 9 : s + 5, 0, 0, 0, 1, 1);
            chk(32'(irq), 32'(s % 2));
            drain();
        end
        gie <= 1'b1;
        sync <= 1'b0;
        cfg(32'h90, 32'h06);
        for (int i = 0; i < 4; i++) send(9'(rnd()), 8, 0, 0, 0, 1, 1);
        acc(1, 0, 32'h1C);
        acc(1, 0, 32'h00);
        q.delete(2);
        q[2][11] = 1'b1;
        drain();
        send(9'(rnd()), 8, 0, 0, 0, 1, 1);
        drain();
        // Disable with a full buffer and a frame in flight
        send(9'(rnd()), 8, 0, 0, 0, 1, 1);
        send(9'(rnd()), 8, 0, 0, 0, 1, 1);
        send(9'(rnd()), 8, 0, 0, 0, 1, 0);
        cfg(32'h80, 32'h06);
        repeat (80) @(posedge pclk);
        q.delete();
        drain();
        cfg(32'h90, 32'h06);
        send(9'(rnd()), 8, 0, 0, 0, 1, 1);
        drain();
        final_report();
    end
    initial begin
        #400000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
